// [logic/tsg_pkg.sv]
package tsg_pkg;
  // Clock and time figures
  localparam int CLK_NS      = 40;
  localparam int MS_NS       = 1_000_000;
  localparam int KHZ_HI_NS   = 100_000;
  localparam int EXT_TMO_NS  = 20_000;
  localparam int MS_CYC      = MS_NS / CLK_NS;
  localparam int KHZ_HI_CYC  = (KHZ_HI_NS + CLK_NS - 1) / CLK_NS;
  localparam int EXT_TMO_CYC = EXT_TMO_NS / CLK_NS;
  // Calendar limits
  localparam logic [9:0] MS_LAST   = 10'h3E7;
  localparam logic [5:0] SEC_LAST  = 6'h3B;
  localparam logic [5:0] MIN_LAST  = 6'h3B;
  localparam logic [4:0] HOUR_LAST = 5'h17;
  localparam logic [8:0] DAY_LAST  = 9'h16E;
  localparam logic [8:0] DAY_FIRST = 9'h001;
  localparam logic [15:0] MS_PER_MIN = 16'hEA5F;
  // Output shapes
  localparam logic [9:0] PPS_HI_MS = 10'h064;
  localparam logic [9:0] BLINK_MS  = 10'h1F4;
  localparam logic [5:0] MARK_MIN  = 6'h02;
  localparam logic [5:0] MARK_HOUR = 6'h04;
  localparam logic [5:0] MARK_DAY  = 6'h06;
  localparam logic [5:0] H60_PER   = 6'h32;
  localparam logic [5:0] H60_B1 = 6'h08, H60_B2 = 6'h10, H60_B3 = 6'h19;
  localparam logic [5:0] H60_B4 = 6'h21, H60_B5 = 6'h29;
  // Unlocked-time thresholds in minutes
  localparam logic [10:0] LOL_1MS   = 11'h008;
  localparam logic [10:0] LOL_5MS   = 11'h016;
  localparam logic [10:0] LOL_50MS  = 11'h05C;
  localparam logic [10:0] LOL_500MS = 11'h528;
  // Register offsets
  localparam logic [3:0] A_CTRL = 4'h0, A_DELAY = 4'h1, A_EXTSEL = 4'h2;
  localparam logic [3:0] A_SET  = 4'h3, A_TIME  = 4'h4, A_STATE  = 4'h5;
  localparam logic [3:0] A_STAT = 4'h6, A_MASK  = 4'h7;
  localparam logic [6:0] EXTSEL_RST = 7'h0A;
  localparam logic [6:0] EXTSEL_MAX = 7'h64;
  // Interrupt bit positions
  localparam int IRQ_SEC = 0, IRQ_MIN = 1, IRQ_LOST = 2, IRQ_COLON = 3, IRQ_DISP = 4;
  localparam int IRQ_W = 5;

  typedef struct packed {
    logic [8:0] day;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } tsg_time_t;

  typedef struct packed {
    logic data_opt;
    logic code2_fit;
    logic code2_am;
    logic code1_dc;
    logic fmt12;
  } tsg_ctrl_t;

  typedef enum logic [2:0] {
    SRC_INT  = 3'b001,
    SRC_EXT  = 3'b010,
    SRC_LOCK = 3'b100
  } tsg_src_t;
endpackage : tsg_pkg

// [logic/tsg_top.sv]
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
// Operation
// - Hours shown in 24-hour form unless the 12-hour select bit is set.
// - Delay is units switch 0-9 ms plus tens switch 0-90 ms.
// - The delay advances the one time counter that feeds every timing output but the kilohertz pulse.
// - One pulse per second high 100 ms from each second start.
// - Kilohertz output high 100 us after each millisecond.
// - Slow mark high two, four or six seconds at minute, hour, day.
// - Complement slow mark rests high and drops for those same lengths.
// - 60 Hz wave with half cycles 8, 8, 9 ms on millisecond edges.
// - External reference 100 kHz to 10 MHz divided down to milliseconds.
// - Without carrier lock run from external reference if present, else crystal.
// - Loss of lock drives drift flags even on external reference.
// - Four accuracy bits encode estimated error from unlocked duration.
// - First code output uses 1 kHz modulation unless set to DC.
// - Second code on modulation forces the first code to DC.
// - Second code replaces pulse per second on the shared connector when it and the data option are both fitted.
// - Colons flash after 92 unlocked minutes since last sync.
// - Whole display flashes after 22 unlocked hours since last sync.
module tsg_top
  import tsg_pkg::*;
#(
  parameter int P_MS_CYC = MS_CYC
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_carrier_lock,
  input  wire logic        i_ext_ref,
  input  wire logic        i_code2_bit,
  output logic             o_pps,
  output logic             o_khz,
  output logic             o_slow_mark,
  output logic             o_slow_mark_n,
  output logic             o_hz60,
  output logic             o_conn_pps,
  output logic             o_code1_mod_sel,
  output logic             o_code2_mod_sel,
  output logic      [4:0]  o_disp_hour,
  output logic             o_colon_on,
  output logic             o_disp_on,
  output logic      [3:0]  o_accuracy,
  output logic             o_time_valid,
  output logic             o_irq
);

  // Map a 24-hour value to 12-hour form
  function automatic logic [4:0] hour12(input logic [4:0] h);
    if (h == 5'h00) hour12 = 5'h0C;
    else if (h > 5'h0C) hour12 = h - 5'h0C;
    else hour12 = h;
  endfunction : hour12

  // Sum of the two decade switches, each clamped to 9
  function automatic logic [9:0] delay_ms(input logic [7:0] d);
    logic [3:0] u;
    logic [3:0] t;
    u = (d[3:0] > 4'h9) ? 4'h9 : d[3:0];
    t = (d[7:4] > 4'h9) ? 4'h9 : d[7:4];
    delay_ms = 10'({t, 3'h0}) + 10'({t, 1'h0}) + 10'(u);
  endfunction : delay_ms

  // Quasi-square phase in a 50 ms group of three cycles
  function automatic logic hz60_level(input logic [5:0] p);
    hz60_level = (p < H60_B1) || (p >= H60_B2 && p < H60_B3) ||
                 (p >= H60_B4 && p < H60_B5);
  endfunction : hz60_level

  // Pin synchronisers; first stages are read only by second stages
  logic lock_m_reg, lock_s_reg, ext_m_reg, ext_s_reg, ext_d_reg;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lock_m_reg <= 1'b0;
      lock_s_reg <= 1'b0;
      ext_m_reg  <= 1'b1;                                // Pulled-up pin rests high
      ext_s_reg  <= 1'b1;                                // No false edge after reset
      ext_d_reg  <= 1'b1;
    end else begin
      lock_m_reg <= i_carrier_lock;
      lock_s_reg <= lock_m_reg;
      ext_m_reg  <= i_ext_ref;
      ext_s_reg  <= ext_m_reg;
      ext_d_reg  <= ext_s_reg;
    end
  end
  wire ext_edge = ext_s_reg && !ext_d_reg;

  // Software registers
  tsg_ctrl_t       ctrl_reg, ctrl_next;
  logic [7:0]      dly_reg, dly_next;
  logic [6:0]      sel_reg, sel_next;
  logic [IRQ_W-1:0] stat_reg, stat_next, mask_reg, mask_next, ev;
  logic [31:0]     rdata_next;
  wire set_wr = i_wr && (i_addr == A_SET);

  // Time base source, divider and reference presence
  tsg_src_t   src_reg, src_next;
  logic [14:0] int_cnt_reg, int_cnt_next;
  logic [13:0] ext_cnt_reg, ext_cnt_next;
  logic [9:0]  idle_reg, idle_next;
  logic        ms_tick;
  wire ext_present = (idle_reg < 10'(EXT_TMO_CYC));
  wire int_tick = (int_cnt_reg == 15'(P_MS_CYC - 1));
  wire [13:0] ext_div = 14'(((sel_reg == 7'h00) ? 7'h01 : sel_reg) * 100);
  wire ext_tick = ext_edge && (ext_cnt_reg >= ext_div - 14'h0001);

  always_comb begin
    src_next     = src_reg;
    int_cnt_next = int_tick ? 15'h0000 : int_cnt_reg + 15'h0001;
    ext_cnt_next = ext_cnt_reg;
    idle_next    = ext_edge ? 10'h000 : idle_reg;
    if (!ext_edge && ext_present) idle_next = idle_reg + 10'h001;
    if (ext_edge) ext_cnt_next = ext_tick ? 14'h0000 : ext_cnt_reg + 14'h0001;
    // Locked carrier disciplines the crystal path
    case (src_reg)
      SRC_LOCK, SRC_EXT, SRC_INT: begin
        if (lock_s_reg) src_next = SRC_LOCK;
        else if (ext_present) src_next = SRC_EXT;
        else src_next = SRC_INT;
      end
      default: src_next = SRC_INT;
    endcase
    ms_tick = (src_reg == SRC_EXT) ? ext_tick : int_tick;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      src_reg     <= SRC_INT;
      int_cnt_reg <= 15'h0000;
      ext_cnt_reg <= 14'h0000;
      idle_reg    <= 10'(EXT_TMO_CYC);
    end else begin
      src_reg     <= src_next;
      int_cnt_reg <= int_cnt_next;
      ext_cnt_reg <= ext_cnt_next;
      idle_reg    <= idle_next;
    end
  end

  // Compensated time of year; set loads the delay into the ms field
  tsg_time_t  t_reg, t_next;
  logic [9:0] ms_reg, ms_next;
  logic       valid_reg, valid_next;
  always_comb begin
    t_next     = t_reg;
    ms_next    = ms_reg;
    valid_next = valid_reg || set_wr;
    if (set_wr) begin
      t_next  = tsg_time_t'(i_wdata[25:0]);
      ms_next = delay_ms(dly_reg);
    end else if (ms_tick) begin
      ms_next = ms_reg + 10'h001;
      if (ms_reg >= MS_LAST) begin
        ms_next    = 10'h000;
        t_next.sec = t_reg.sec + 6'h01;
        if (t_reg.sec >= SEC_LAST) begin
          t_next.sec = 6'h00;
          t_next.min = t_reg.min + 6'h01;
          if (t_reg.min >= MIN_LAST) begin
            t_next.min  = 6'h00;
            t_next.hour = t_reg.hour + 5'h01;
            if (t_reg.hour >= HOUR_LAST) begin
              t_next.hour = 5'h00;
              t_next.day  = (t_reg.day >= DAY_LAST) ? DAY_FIRST : t_reg.day + 9'h001;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      t_reg     <= '{day: DAY_FIRST, default: '0};
      ms_reg    <= 10'h000;
      valid_reg <= 1'b0;
    end else begin
      t_reg     <= t_next;
      ms_reg    <= ms_next;
      valid_reg <= valid_next;
    end
  end

  // Unlocked duration since last sync, counted on the active time base
  logic [15:0] lol_ms_reg, lol_ms_next;
  logic [10:0] lol_min_reg, lol_min_next;
  logic [3:0]  acc;
  always_comb begin
    lol_ms_next  = lol_ms_reg;
    lol_min_next = lol_min_reg;
    if (set_wr) begin
      lol_ms_next  = 16'h0000;
      lol_min_next = 11'h000;
    end else if (ms_tick && !lock_s_reg && valid_reg) begin
      lol_ms_next = lol_ms_reg + 16'h0001;
      if (lol_ms_reg >= MS_PER_MIN) begin
        lol_ms_next = 16'h0000;
        if (lol_min_reg < LOL_500MS) lol_min_next = lol_min_reg + 11'h001;
      end
    end
    acc[0] = lol_min_reg >= LOL_1MS;
    acc[1] = lol_min_reg >= LOL_5MS;
    acc[2] = lol_min_reg >= LOL_50MS;
    acc[3] = (lol_min_reg >= LOL_500MS) || !valid_reg;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lol_ms_reg  <= 16'h0000;
      lol_min_reg <= 11'h000;
    end else begin
      lol_ms_reg  <= lol_ms_next;
      lol_min_reg <= lol_min_next;
    end
  end

  // Kilohertz high-time counter, reloaded on every millisecond
  logic [11:0] khz_reg, khz_next;
  always_comb begin
    khz_next = khz_reg;
    if (ms_tick) khz_next = 12'(KHZ_HI_CYC);
    else if (khz_reg != 12'h000) khz_next = khz_reg - 12'h001;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) khz_reg <= 12'h000;
    else khz_reg <= khz_next;
  end

  // Registered outputs; all edges from the one ms counter except both kHz edges, timed by khz_reg
  logic [5:0] mark_len;
  logic       mark, pps_n, acc2_d_reg, acc3_d_reg, lock_d_reg;
  always_comb begin
    mark_len = MARK_MIN;
    if (t_reg.min == 6'h00) mark_len = MARK_HOUR;
    if (t_reg.min == 6'h00 && t_reg.hour == 5'h00) mark_len = MARK_DAY;
    mark  = valid_reg && (t_reg.sec < mark_len);
    pps_n = ms_reg < PPS_HI_MS;
    ev = '0;
    ev[IRQ_SEC]   = ms_tick && (ms_reg >= MS_LAST);
    ev[IRQ_MIN]   = ev[IRQ_SEC] && (t_reg.sec >= SEC_LAST);
    ev[IRQ_LOST]  = lock_d_reg && !lock_s_reg;
    ev[IRQ_COLON] = acc[2] && !acc2_d_reg;
    ev[IRQ_DISP]  = acc[3] && !acc3_d_reg;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pps           <= 1'b0;
      o_khz           <= 1'b0;
      o_slow_mark     <= 1'b0;
      o_slow_mark_n   <= 1'b1;
      o_hz60          <= 1'b0;
      o_conn_pps      <= 1'b0;
      o_code1_mod_sel <= 1'b1;
      o_code2_mod_sel <= 1'b0;
      o_disp_hour     <= 5'h00;
      o_colon_on      <= 1'b1;
      o_disp_on       <= 1'b0;
      o_accuracy      <= 4'h8;
      o_time_valid    <= 1'b0;
      acc2_d_reg      <= 1'b0;
      acc3_d_reg      <= 1'b1;
      lock_d_reg      <= 1'b0;
    end else begin
      o_pps           <= pps_n;
      o_khz           <= khz_reg != 12'h000;
      o_slow_mark     <= mark;
      o_slow_mark_n   <= !mark;
      o_hz60          <= hz60_level(6'(ms_reg % 10'(H60_PER)));
      // Second code takes the shared connector when data options fitted
      o_conn_pps      <= (ctrl_reg.code2_fit && ctrl_reg.data_opt) ? i_code2_bit
                                                                  : pps_n;
      o_code2_mod_sel <= ctrl_reg.code2_am;
      o_code1_mod_sel <= !ctrl_reg.code2_am && !ctrl_reg.code1_dc;
      o_disp_hour     <= ctrl_reg.fmt12 ? hour12(t_reg.hour) : t_reg.hour;
      o_colon_on      <= !(acc[2] && ms_reg >= BLINK_MS);
      o_disp_on       <= valid_reg && !(acc[3] && ms_reg >= BLINK_MS);
      o_accuracy      <= acc;
      o_time_valid    <= valid_reg;
      acc2_d_reg      <= acc[2];
      acc3_d_reg      <= acc[3];
      lock_d_reg      <= lock_s_reg;
    end
  end

  // Register writes, sticky status (set beats clear) and read mux
  always_comb begin
    ctrl_next = ctrl_reg;
    dly_next  = dly_reg;
    sel_next  = sel_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    if (i_wr) begin
      case (i_addr)
        A_CTRL:   ctrl_next = tsg_ctrl_t'(i_wdata[4:0]);
        A_DELAY:  dly_next  = i_wdata[7:0];
        A_EXTSEL: sel_next  = (i_wdata[6:0] > EXTSEL_MAX) ? EXTSEL_MAX : i_wdata[6:0];
        A_MASK:   mask_next = i_wdata[IRQ_W-1:0];
        A_STAT:   stat_next = stat_reg & ~i_wdata[IRQ_W-1:0];
        default:  ;
      endcase
    end
    stat_next  = stat_next | ev;
    rdata_next = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        A_CTRL:   rdata_next = {27'h000_0000, ctrl_reg};
        A_DELAY:  rdata_next = {24'h00_0000, dly_reg};
        A_EXTSEL: rdata_next = {25'h000_0000, sel_reg};
        A_TIME:   rdata_next = {6'h00, t_reg};
        A_STATE:  rdata_next = {12'h000, src_reg, ext_present, lock_s_reg, valid_reg,
                                acc, ms_reg};
        A_STAT:   rdata_next = {27'h000_0000, stat_reg};
        A_MASK:   rdata_next = {27'h000_0000, mask_reg};
        default:  rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_reg <= '0;
      dly_reg  <= 8'h00;
      sel_reg  <= EXTSEL_RST;
      mask_reg <= '0;
      stat_reg <= '0;
      o_rdata  <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      dly_reg  <= dly_next;
      sel_reg  <= sel_next;
      mask_reg <= mask_next;
      stat_reg <= stat_next;
      o_rdata  <= rdata_next;
    end
  end

  assign o_irq = |(stat_reg & mask_reg);

  a_pps_rise: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $rose(o_pps) |-> ($past(ms_reg) == 10'h000 || $past(set_wr, 2)))
    else $error("pps rose away from second start");
  a_khz_load: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    ms_tick |=> (khz_reg == 12'(KHZ_HI_CYC)) ##1 o_khz)
    else $error("kHz pulse not started on ms");
  a_h60_edge: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $changed(o_hz60) |-> ($past(ms_tick, 2) || $past(set_wr, 2) || !$past(i_rst_n, 2)))
    else $error("60 Hz edge off a ms boundary");
  a_mark_short: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (o_slow_mark && $past(t_reg.min) != 6'h00) |-> $past(t_reg.sec) < MARK_MIN)
    else $error("minute mark too long");
  a_mark_pair: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_slow_mark_n != o_slow_mark)
    else $error("slow mark complement wrong");
  a_src_ext: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!lock_s_reg && ext_present) |=> src_reg == SRC_EXT)
    else $error("external reference not selected");
  a_delay_load: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    set_wr |=> ms_reg == delay_ms($past(dly_reg)))
    else $error("delay not applied at set");
  a_colon_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (lol_min_reg >= LOL_50MS) |=> o_accuracy[2])
    else $error("colon flash flag missing");
  a_disp_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (lol_min_reg < LOL_500MS && valid_reg) |=> !o_accuracy[3])
    else $error("display flash flag early");
  a_hour_map: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    ($past(ctrl_reg.fmt12) && $past(ctrl_reg.fmt12, 2)) |->
      (o_disp_hour >= 5'h01 && o_disp_hour <= 5'h0C))
    else $error("12-hour value out of range");
  a_mod_share: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !(o_code1_mod_sel && o_code2_mod_sel))
    else $error("both codes on the modulator");

endmodule : tsg_top

// [sim/tsg_far_model.sv]
`timescale 1ns/1ps
// Far side: carrier receiver, lab reference oscillator and second code source
module tsg_far_model #(
  parameter int P_EXT_HALF_NS = 50
) (
  input  wire logic i_lock_cmd,
  input  wire logic i_ext_on,
  input  wire logic i_code2_lvl,
  output logic      o_carrier_lock,
  output logic      o_ext_ref,
  output logic      o_code2_bit
);
  // 10 MHz reference, a 100 kHz multiple
  // The odd start offset keeps its edges off the system clock edges
  // Absent oscillator leaves the pulled-up input resting high
  initial begin
    o_ext_ref = 1'b1;
    #7;
    forever begin
      #P_EXT_HALF_NS;
      o_ext_ref = i_ext_on ? ~o_ext_ref : 1'b1;
    end
  end
  // Lock state and code level follow the bench's commands
  assign o_carrier_lock = i_lock_cmd;
  assign o_code2_bit    = i_code2_lvl;
endmodule : tsg_far_model

// [sim/testbench.sv]
`timescale 1ns/1ps
// Timing output bench; ms shortened to P_MS cycles to keep marks reachable
module testbench;
  import tsg_pkg::*;
  localparam int P_MS    = 4;
  localparam int SEC_CYC = 1000 * P_MS;
  localparam int K_MS    = 3000;
  localparam int HZ_EDGE[6] = '{8, 16, 25, 33, 41, 50};
  localparam int MK_HR[3]   = '{5, 5, 23};
  localparam int MK_MIN[3]  = '{5, 59, 59};
  localparam int MK_DLY[3]  = '{8'h99, 8'hF3, 8'h0A};
  localparam int MK_SEC[3]  = '{2, 4, 6};
  logic        i_mclk    = 1'b0;
  logic        i_rst_n   = 1'b0;
  logic [3:0]  addr      = 4'h0;
  logic [31:0] wdata     = 32'h0000_0000;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic        lock_cmd  = 1'b1;
  logic        ext_on    = 1'b1;
  logic        code2_lvl = 1'b0;
  logic        carrier_lock, ext_ref, code2_bit, pps, khz, mark, mark_n, hz60, conn;
  logic        c1_sel, c2_sel, colon_on, disp_on, valid, irq, k_khz, h;
  logic [4:0]  disp_hour;
  logic [3:0]  acc;
  logic [31:0] rdata, rv;
  int          error_cnt = 0;
  int          n_tests   = 0;
  int          cyc       = 0;
  int          n, pf, bad, dd;
  int          q[$];
  tsg_time_t   t;

  tsg_far_model far_u (.i_lock_cmd(lock_cmd), .i_ext_on(ext_on), .i_code2_lvl(code2_lvl),
    .o_carrier_lock(carrier_lock), .o_ext_ref(ext_ref), .o_code2_bit(code2_bit));
  tsg_top #(.P_MS_CYC(P_MS)) dut_u (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_carrier_lock(carrier_lock), .i_ext_ref(ext_ref),
    .i_code2_bit(code2_bit), .o_pps(pps), .o_khz(khz), .o_slow_mark(mark),
    .o_slow_mark_n(mark_n), .o_hz60(hz60), .o_conn_pps(conn), .o_code1_mod_sel(c1_sel),
    .o_code2_mod_sel(c2_sel), .o_disp_hour(disp_hour), .o_colon_on(colon_on),
    .o_disp_on(disp_on), .o_accuracy(acc), .o_time_valid(valid), .o_irq(irq));
  // Longer ms copy: the 1 kHz high time is fixed in cycles, so it needs an ms longer than that high time
  tsg_top #(.P_MS_CYC(K_MS)) dut_k (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(), .i_carrier_lock(carrier_lock), .i_ext_ref(ext_ref), .i_code2_bit(code2_bit),
    .o_pps(), .o_khz(k_khz), .o_slow_mark(), .o_slow_mark_n(), .o_hz60(), .o_conn_pps(),
    .o_code1_mod_sel(), .o_code2_mod_sel(), .o_disp_hour(), .o_colon_on(), .o_disp_on(),
    .o_accuracy(), .o_time_valid(), .o_irq());

  // 25 MHz clock and a hang limit
  always #20 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic tick();
    @(posedge i_mclk);
    #1;
  endtask : tick

  // Bus cycles: one strobe cycle, read data in the following cycle only
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge i_mclk);
    wr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge i_mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : bus_rd

  task automatic chk(input string m, input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  task automatic chk_rng(input string m, input int g, input int lo, input int hi);
    n_tests++;
    if (g < lo || g > hi) begin
      error_cnt++;
      $display("[ERR] %0t %s got %0d exp %0d..%0d", $time, m, g, lo, hi);
    end
  endtask : chk_rng

  task automatic complete_run();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  // Reference model pieces
  function automatic logic [4:0] hour12(input int hr, input bit f);
    if (!f || (hr >= 1 && hr <= 12)) return hr[4:0];
    return (hr == 0) ? 5'h0C : 5'(hr - 12);
  endfunction : hour12

  function automatic int clamp9(input int v);
    return (v > 9) ? 9 : v;
  endfunction : clamp9

  function automatic logic sig(input int s);
    case (s)
      0: return k_khz;
      1: return pps;
      default: return hz60;
    endcase
  endfunction : sig

  // Counts cycles while the chosen output keeps level v
  task automatic hold(input int s, input logic v, output int c);
    c = 0;
    while (sig(s) === v && c < 30000) begin
      tick();
      c++;
    end
  endtask : hold

  initial begin
    void'($urandom(32'hf6c9828d));
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    tick();
    // Nothing is trusted before the time is set
    chk("valid", valid, 1'b0);
    chk("disp off", disp_on, 1'b0);
    chk("accuracy", acc, 4'h8);
    chk("mark_n idle", mark_n, 1'b1);
    // Reset values; the unmapped write must leave no trace
    bus_wr(4'hC, 32'hFFFF_FFFF);
    for (int a = 0; a < 16; a++) begin
      if (a >= 3 && a <= 7) continue;
      bus_rd(4'(a), rv);
      chk("reg reset", rv, (a == 2) ? 32'(EXTSEL_RST) : 32'h0000_0000);
    end
    // Reference selection above 10 MHz is clamped to the top setting
    bus_wr(A_EXTSEL, 32'h0000_00FF);
    bus_rd(A_EXTSEL, rv);
    chk("extsel clamp", rv, 32'(EXTSEL_MAX));
    // Kilohertz pulse widths
    hold(0, 1'b0, n);
    hold(0, 1'b1, n);
    chk_rng("khz high", n, KHZ_HI_CYC, KHZ_HI_CYC);
    hold(0, 1'b0, n);
    chk_rng("khz low", n, K_MS - KHZ_HI_CYC, K_MS - KHZ_HI_CYC);
    // Every hour in both display formats
    for (int f = 0; f < 2; f++) begin
      bus_wr(A_CTRL, 32'(f));
      for (int hr = 0; hr < 24; hr++) begin
        t = '{day: 9'($urandom_range(366, 1)), hour: 5'(hr),
              min: 6'($urandom_range(58)), sec: 6'($urandom_range(58))};
        bus_wr(A_SET, 32'(t));
        tick();
        tick();
        chk("disp hour", disp_hour, hour12(hr, f[0]));
      end
    end
    bus_rd(A_TIME, rv);
    chk("time read", rv, 32'(t));
    chk("valid set", valid, 1'b1);
    chk("disp on", disp_on, 1'b1);
    chk("acc clear", acc, 4'h0);
    chk("colon on", colon_on, 1'b1);
    // The shortened ms is below the fixed high time, so this copy never falls
    chk("khz held", khz, (KHZ_HI_CYC > P_MS) ? 1'b1 : 1'b0);
    // Code routing, all CTRL codes, while the second pulse is low
    hold(1, 1'b1, n);
    for (int c = 0; c < 32; c++) begin
      code2_lvl <= 1'($urandom_range(1));
      bus_wr(A_CTRL, 32'(c));
      tick();
      tick();
      chk("code1 sel", c1_sel, !(c[1] || c[2]));
      chk("code2 sel", c2_sel, c[2]);
      chk("connector", conn, (c[3] && c[4]) ? code2_lvl : 1'b0);
    end
    bus_wr(A_CTRL, 32'h0000_0000);
    // Minute, hour and day marks under three delay settings, clamps included
    for (int i = 0; i < 3; i++) begin
      bus_wr(A_DELAY, 32'(MK_DLY[i]));
      t = '{day: 9'($urandom_range(365, 1)), hour: 5'(MK_HR[i]), min: 6'(MK_MIN[i]),
            sec: 6'h3B};
      bus_wr(A_SET, 32'(t));
      dd = clamp9(MK_DLY[i] >> 4) * 10 + clamp9(MK_DLY[i] & 15);
      tick();
      tick();
      hold(1, 1'b1, n);
      hold(1, 1'b0, pf);
      chk_rng("to second", n + pf + 2, (1000 - dd) * P_MS - P_MS,
              (1000 - dd) * P_MS + P_MS + 2);
      chk("mark start", mark, 1'b1);
      chk("hz60 align", hz60, 1'b1);
      n = 0;
      pf = 0;
      bad = 0;
      h = 1'b1;
      q.delete();
      while (mark === 1'b1 && n < 30000) begin
        if (mark_n !== 1'b0) bad++;
        if (hz60 !== h && q.size() < 6) q.push_back(n);
        h = hz60;
        if (pps === 1'b0 && pf == 0) pf = n;
        tick();
        n++;
      end
      chk_rng("mark width", n, MK_SEC[i] * SEC_CYC, MK_SEC[i] * SEC_CYC);
      chk("mark_n low", bad, 0);
      chk("mark_n rest", mark_n, 1'b1);
      chk_rng("pps width", pf, 100 * P_MS, 100 * P_MS);
      for (int k = 0; k < 6; k++) begin
        chk_rng("hz60 edge", (k < q.size()) ? q[k] : -1, HZ_EDGE[k] * P_MS,
                HZ_EDGE[k] * P_MS);
      end
    end
    // Lost carrier: reference takes over, drift event still raised
    bus_wr(A_EXTSEL, 32'h0000_0001);
    bus_wr(A_MASK, 32'(1 << IRQ_LOST));
    bus_wr(A_STAT, 32'h0000_001F);
    tick();
    chk("irq idle", irq, 1'b0);
    bus_rd(A_STATE, rv);
    chk("src lock", rv[19:17], SRC_LOCK);
    lock_cmd <= 1'b0;
    repeat (8) tick();
    chk("irq lost", irq, 1'b1);
    bus_rd(A_STATE, rv);
    chk("src ext", rv[19:17], SRC_EXT);
    chk("acc short loss", acc, 4'h0);
    chk("colon short loss", colon_on, 1'b1);
    bus_wr(A_STAT, 32'(1 << IRQ_LOST));
    tick();
    chk("irq clear", irq, 1'b0);
    // Three 60 Hz halves are 25 ms of 100 reference edges, 100 ns apart
    hold(2, hz60, n);
    pf = 0;
    for (int k = 0; k < 3; k++) begin
      hold(2, hz60, n);
      pf += n;
    end
    chk_rng("ext ms", pf, 6250 - 4, 6250 + 4);
    ext_on <= 1'b0;
    repeat (EXT_TMO_CYC + 10) tick();
    bus_rd(A_STATE, rv);
    chk("src int", rv[19:17], SRC_INT);
    // A masked event holds the line low until unmasked
    bus_wr(A_MASK, 32'h0000_0000);
    lock_cmd <= 1'b1;
    repeat (8) tick();
    lock_cmd <= 1'b0;
    repeat (8) tick();
    chk("irq masked", irq, 1'b0);
    bus_wr(A_MASK, 32'(1 << IRQ_LOST));
    tick();
    chk("irq unmask", irq, 1'b1);
    complete_run();
  end
endmodule : testbench
